// File: pkg/rhs_pkg.sv
// constants, types and helpers shared by the reader host serial controller
//
// Contract
// - host reads fifo status, then fifo data
// - fifo interrupts repeat until receive complete
// - host clears fifo with reset command first
// - host writes length bytes then fifo continuously
// - host checks status and tops up fifo
// - host follows status read with dummy read
// - dummy read: start, 0x6C, two reads, stop
// - no select: data rise, clock high starts
// - no select: data changes while clock low
// - every word eight bits, msb first
// - select high holds reset and ends transfer
// - host holds data static during read phase
package rhs_pkg;

  // timing of the serial clock made by this end
  localparam int CLK_PERIOD_NS = 100;                 // system clock period
  localparam int SCLK_HALF_NS  = 400;                 // least half period of sclk
  localparam int HALF_CYC      = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1); // last count of a half period

  // wishbone byte addresses of the controller registers
  localparam logic [7:0] ADR_CTRL    = 8'h00;         // mode and auto service enable
  localparam logic [7:0] ADR_OP      = 8'h04;         // link operation launch
  localparam logic [7:0] ADR_STATUS  = 8'h08;         // engine state
  localparam logic [7:0] ADR_RXDATA  = 8'h0C;         // last byte read by software op
  localparam logic [7:0] ADR_IRQSTAT = 8'h10;         // interrupt status caught by service

  // control register fields
  localparam int CTRL_NO_SS = 0;                      // 1: spi without slave select
  localparam int CTRL_AUTO  = 1;                      // 1: service interrupt pin alone
  localparam logic [1:0] CTRL_RESET = 2'h0;           // reset value of control bits

  // operation register fields
  localparam int OP_CODE_LSB = 8;                     // op code sits in bits 9:8

  // status register fields
  localparam int STS_BUSY    = 0;                     // op pending or running
  localparam int STS_IRQ     = 1;                     // synchronised interrupt pin
  localparam int STS_FRAME   = 2;                     // software link frame open
  localparam int STS_IRQ_NEW = 3;                     // fresh interrupt status captured
  localparam int STS_RX_NEW  = 4;                     // fresh read byte available

  // device register map reached over the link
  localparam logic [4:0] DEV_IRQ_STATUS  = 5'h0C;     // interrupt_status
  localparam logic [4:0] DEV_IRQ_MASK    = 5'h0D;     // collision_position_irq_mask
  localparam logic [4:0] DEV_FIFO_STATUS = 5'h1C;     // fifo_level_status
  localparam logic [4:0] DEV_TX_LEN_HIGH = 5'h1D;     // tx_length_high
  localparam logic [4:0] DEV_TX_LEN_LOW  = 5'h1E;     // tx_length_low_broken
  localparam logic [4:0] DEV_FIFO_DATA   = 5'h1F;     // fifo_data_port

  // address word layout and command codes
  localparam int AW_CMD  = 7;                         // 1: command word
  localparam int AW_READ = 6;                         // 1: read
  localparam int AW_CONT = 5;                         // 1: continuous address
  localparam logic [7:0] CMD_FIFO_RESET = 8'h0F;      // fifo reset command code

  // device interrupt status bit positions
  localparam int IRQ_TX_BIT  = 7;                     // transmit flag
  localparam int IRQ_SOF_BIT = 6;                     // receive start flag

  // one link operation
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_STOP  = 2'h3
  } rhs_op_type;

  typedef struct packed {
    rhs_op_type op;                                   // what to do
    logic [7:0] data;                                 // byte to send
  } rhs_req_type;

  // link engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOW  = 5'h02,
    ST_HIGH = 5'h04,
    ST_DLM  = 5'h08,
    ST_DONE = 5'h10
  } rhs_state_type;

  // builds an address word for register access
  function automatic logic [7:0] rhs_addr_word(input logic rd, input logic cont, input logic [4:0] adr);
    rhs_addr_word = {1'b0, rd, cont, adr};
  endfunction

endpackage

// File: logic/rhs_sync.sv
// two flip-flop synchroniser for pins entering the clock domain
`timescale 1ns/100ps
`default_nettype none
module rhs_sync (
  input  wire logic       clk_i,  // system clock
  input  wire logic       rst_i,  // synchronous reset, active high
  input  wire logic [1:0] pin_i,  // asynchronous pins
  output logic      [1:0] sync_o  // synchronised levels
);

  logic [1:0] meta;               // first stage, read only by second

  // two stages, reset to low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= 2'h0;
      sync_o <= 2'h0;
    end else begin
      meta   <= pin_i;
      sync_o <= meta;
    end
  end

endmodule // rhs_sync
`default_nettype wire

// File: logic/rhs_shifter.sv
// byte shift register, msb out first, sampled bit in at the bottom
`timescale 1ns/100ps
`default_nettype none
module rhs_shifter (
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_i,   // synchronous reset, active high
  input  wire logic       load_i,  // load a new byte
  input  wire logic [7:0] data_i,  // byte to load
  input  wire logic       shift_i, // shift one place
  input  wire logic       bit_i,   // bit shifted in
  output logic      [7:0] data_o   // current contents
);

  // load wins over shift
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
    end else if (load_i) begin
      data_o <= data_i;
    end else if (shift_i) begin
      data_o <= {data_o[6:0], bit_i};
    end
  end

endmodule // rhs_shifter
`default_nettype wire

// File: logic/rhs_host.sv
// host controller for the reader serial port, with a wishbone register slave
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rhs_host
  import rhs_pkg::*;
(
  input  wire logic        clk_i,     // system clock, 10 MHz
  input  wire logic        rst_i,     // synchronous reset, active high
  input  wire logic        wb_cyc_i,  // wishbone cycle
  input  wire logic        wb_stb_i,  // wishbone strobe
  input  wire logic        wb_we_i,   // wishbone write enable
  input  wire logic [7:0]  wb_adr_i,  // wishbone byte address
  input  wire logic [31:0] wb_dat_i,  // wishbone write data
  input  wire logic [3:0]  wb_sel_i,  // wishbone byte selects
  output logic      [31:0] wb_dat_o,  // wishbone read data
  output logic             wb_ack_o,  // wishbone acknowledge
  output logic             sclk_o,    // serial clock to reader
  output logic             mosi_o,    // serial data to reader
  output logic             ss_n_o,    // slave select, active low
  input  wire logic        miso_i,    // serial data from reader
  input  wire logic        irq_i      // interrupt request from reader
);

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic [1:0] pins_s;                 // synchronised miso and irq
  wire        miso_s = pins_s[0];     // sampled read data
  wire        irq_s  = pins_s[1];     // interrupt level

  rhs_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  ({irq_i, miso_i}),
    .sync_o (pins_s)
  );

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic [1:0]    ctrl;                // control bits
  logic [9:0]    op_reg;              // last op written
  logic          sw_pend;             // software op waiting
  logic [7:0]    rx_data;             // last software read byte
  logic [7:0]    irq_stat;            // captured interrupt status
  logic          irq_new;             // sticky: new status captured
  logic          rx_new;              // sticky: new read byte
  logic          frame_open;          // software start sent, stop not yet
  rhs_state_type state;               // engine state
  logic [2:0]    hcnt;                // half period timer
  logic [2:0]    bitn;                // bit or delimiter step
  rhs_req_type   cur;                 // op in progress
  logic          svc_active;          // interrupt service running
  logic [2:0]    svc_step;            // service sequence step
  logic          svc_armed;           // pin must fall before next service
  logic [7:0]    shreg;               // shift register contents, read by capture and engine

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  wire req      = wb_cyc_i & wb_stb_i;            // request present
  wire acc      = req & wb_ack_o;                 // access takes effect now
  wire wr       = acc & wb_we_i;                  // write edge
  wire rd       = acc & ~wb_we_i;                 // read edge
  wire hit_ctrl = wb_adr_i == ADR_CTRL;           // control selected
  wire hit_op   = wb_adr_i == ADR_OP;             // op selected
  wire hit_sts  = wb_adr_i == ADR_STATUS;         // status selected
  wire hit_rx   = wb_adr_i == ADR_RXDATA;         // read byte selected
  wire hit_irq  = wb_adr_i == ADR_IRQSTAT;        // irq status selected
  wire no_ss    = ctrl[CTRL_NO_SS];               // mode without select
  wire busy     = sw_pend | svc_active | (state != ST_IDLE);

  // op launch only while idle, both low lanes selected
  wire op_wr    = wr & hit_op & wb_sel_i[0] & wb_sel_i[1] & ~busy;

  logic [4:0] sts_bits;               // status register contents
  assign sts_bits = {rx_new, irq_new, frame_open, irq_s, busy};

  // read multiplexer, unmapped reads zero
  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? {30'h0, ctrl}     :
                  hit_op   ? {22'h0, op_reg}   :
                  hit_sts  ? {27'h0, sts_bits} :
                  hit_rx   ? {24'h0, rx_data}  :
                  hit_irq  ? {24'h0, irq_stat} : 32'h0;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // control register: mode select stands in for the strap choice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (wr & hit_ctrl & wb_sel_i[0] & ~busy) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  // ---------------------------------------------------------------
  // op source selection
  // ---------------------------------------------------------------
  wire idle    = state == ST_IDLE;
  wire svc_go  = svc_active & idle;                // service op issue
  wire sw_go   = sw_pend & ~svc_active & idle;     // software op issue
  wire eng_go  = svc_go | sw_go;                   // engine takes an op
  wire eng_done = state == ST_DONE;                // op finished this cycle

  // service sequence: status read with trailing dummy read
  rhs_req_type svc_req;
  assign svc_req.op   = (svc_step == 3'h0) ? OP_START :
                        (svc_step == 3'h1) ? OP_WRITE :
                        (svc_step == 3'h4) ? OP_STOP  : OP_READ;
  assign svc_req.data = rhs_addr_word(1'b1, 1'b1, DEV_IRQ_STATUS);

  // software op from the op register
  rhs_req_type sw_req;
  assign sw_req.op   = rhs_op_type'(op_reg[OP_CODE_LSB +: 2]);
  assign sw_req.data = op_reg[7:0];

  rhs_req_type next_req;
  assign next_req = svc_go ? svc_req : sw_req;

  // op register and pending flag; software builds reset and load frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_reg  <= 10'h000;
      sw_pend <= 1'b0;
    end else if (op_wr) begin
      op_reg  <= wb_dat_i[9:0];
      sw_pend <= 1'b1;
    end else if (sw_go) begin
      sw_pend <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // automatic interrupt service
  // ---------------------------------------------------------------
  wire svc_start = ctrl[CTRL_AUTO] & irq_s & svc_armed & ~svc_active
                   & ~sw_pend & ~frame_open & idle;

  // walk start, address, status byte, dummy byte, stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      svc_active <= 1'b0;
      svc_step   <= 3'h0;
      svc_armed  <= 1'b1;
    end else if (svc_start) begin
      svc_active <= 1'b1;
      svc_step   <= 3'h0;
      svc_armed  <= 1'b0;
    end else begin
      if (svc_active & eng_done) begin
        svc_step   <= svc_step + 3'h1;
        svc_active <= svc_step != 3'h4;
      end
      if (~svc_active & ~irq_s) begin
        svc_armed <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // captured bytes and sticky flags; set wins over read clear
  // ---------------------------------------------------------------
  wire cap_irq = svc_active & eng_done & (svc_step == 3'h2);
  wire cap_rx  = ~svc_active & eng_done & (cur.op == OP_READ);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 8'h00;
      irq_new  <= 1'b0;
    end else if (cap_irq) begin
      irq_stat <= shreg;
      irq_new  <= 1'b1;
    end else if (rd & hit_irq) begin
      irq_new  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data <= 8'h00;
      rx_new  <= 1'b0;
    end else if (cap_rx) begin
      rx_data <= shreg;
      rx_new  <= 1'b1;
    end else if (rd & hit_rx) begin
      rx_new  <= 1'b0;
    end
  end

  // frame tracking keeps the service out of a software frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_open <= 1'b0;
    end else if (eng_done & (cur.op == OP_START)) begin
      frame_open <= ~svc_active;
    end else if (eng_done & (cur.op == OP_STOP)) begin
      frame_open <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // byte shifter
  // ---------------------------------------------------------------
  wire half_done = hcnt == HALF_LAST;               // half period over
  wire is_read   = cur.op == OP_READ;               // read phase
  wire bit_edge  = (state == ST_HIGH) & half_done;  // falling edge next
  wire [7:0] load_byte = (next_req.op == OP_READ) ? 8'h00 : next_req.data;

  rhs_shifter u_shift (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (eng_go),
    .data_i  (load_byte),
    .shift_i (bit_edge),
    .bit_i   (miso_s),
    .data_o  (shreg)
  );

  // ---------------------------------------------------------------
  // delimiter levels: start is a data rise, stop a data fall
  // ---------------------------------------------------------------
  wire dlm_first = cur.op == OP_STOP;              // data level before edge
  wire dlm_last  = cur.op == OP_START;             // data level after edge

  // ---------------------------------------------------------------
  // half period timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i | eng_go | half_done) begin
      hcnt <= 3'h0;
    end else if (~idle) begin
      hcnt <= hcnt + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // link engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= ST_IDLE;
      bitn   <= 3'h0;
      cur    <= '0;
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      ss_n_o <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (eng_go) begin
            cur  <= next_req;
            bitn <= 3'h0;
            if ((next_req.op == OP_START) | (next_req.op == OP_STOP)) begin
              state <= ST_DLM;
              if (no_ss) begin
                mosi_o <= next_req.op == OP_STOP;
              end else begin
                ss_n_o <= next_req.op == OP_STOP;
              end
            end else begin
              state  <= ST_LOW;
              mosi_o <= load_byte[7];
            end
          end
        end
        ST_LOW: begin
          if (half_done) begin
            sclk_o <= 1'b1;                       // device samples here
            state  <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_done) begin
            sclk_o <= 1'b0;
            if (bitn == 3'h7) begin
              state <= ST_DONE;
            end else begin
              bitn   <= bitn + 3'h1;
              mosi_o <= ~is_read & shreg[6];
              state  <= ST_LOW;
            end
          end
        end
        ST_DLM: begin
          if (half_done) begin
            if (~no_ss | (bitn == 3'h3)) begin
              sclk_o <= 1'b0;
              state  <= ST_DONE;
            end else begin
              bitn <= bitn + 3'h1;
              case (bitn)
                3'h0: begin
                  sclk_o <= 1'b1;                 // clock high first
                end
                3'h1: begin
                  mosi_o <= dlm_last;
                end
                default: begin
                  sclk_o <= 1'b0;
                end
              endcase
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // dlm_first drives nothing; the first delimiter level comes from next_req.op
  wire unused_dlm = dlm_first;

endmodule // rhs_host
`default_nettype wire

// File: dv/rhs_host_monitor.sv
// pin level checks for the reader host serial controller
`timescale 1ns/100ps
`default_nettype none
module rhs_host_monitor (
  input wire logic        clk_i,    // clock
  input wire logic        rst_i,    // reset
  input wire logic        wb_cyc_i, // cycle
  input wire logic        wb_stb_i, // strobe
  input wire logic        wb_we_i,  // write
  input wire logic [7:0]  wb_adr_i, // address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [3:0]  wb_sel_i, // selects
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic        wb_ack_o, // ack
  input wire logic        sclk_o,   // serial clock
  input wire logic        mosi_o,   // serial out
  input wire logic        ss_n_o,   // select
  input wire logic        miso_i,   // serial in
  input wire logic        irq_i     // interrupt
);
  logic [3:0] rises;  // sclk rises inside a select frame
  // count clock rises while selected
  always_ff @(posedge clk_i) begin
    if (rst_i || ss_n_o)
      rises <= 4'h0;
    else if ($rose(sclk_o))
      rises <= rises + 4'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_mosi_low; !ss_n_o && $changed(mosi_o) |-> !sclk_o; endproperty
  property p_sclk_high; $rose(sclk_o) |-> sclk_o [*4]; endproperty
  property p_sclk_low; !ss_n_o && $fell(sclk_o) |-> !sclk_o [*4]; endproperty
  property p_bits8; $rose(ss_n_o) |-> rises[2:0] == 3'h0; endproperty
  property p_ss_edge; $changed(ss_n_o) |-> !sclk_o; endproperty
  property p_reset_idle; $fell(rst_i) |-> ss_n_o && !sclk_o && !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held too long");
  a_ack_answer: assert property (p_ack_answer)
    else $error("ack missing");
  a_mosi_low: assert property (p_mosi_low)
    else $error("mosi moved with sclk high");
  a_sclk_high: assert property (p_sclk_high)
    else $error("sclk high too short");
  a_sclk_low: assert property (p_sclk_low)
    else $error("sclk low too short");
  a_bits8: assert property (p_bits8)
    else $error("frame not whole bytes");
  a_ss_edge: assert property (p_ss_edge)
    else $error("select moved with sclk high");
  a_reset_idle: assert property (p_reset_idle)
    else $error("pins not idle after reset");
  c_frame: cover property ($rose(ss_n_o));
  c_write: cover property (wb_ack_o && wb_we_i);
  c_irq: cover property ($fell(irq_i));
endmodule // rhs_host_monitor
bind rhs_host rhs_host_monitor i_rhs_host_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .sclk_o, .mosi_o, .ss_n_o, .miso_i, .irq_i);
`default_nettype wire

// File: dv/rhs_dev_model.sv
// behavioural reader front end with its register file
`timescale 1ns/100ps
`default_nettype none
module rhs_dev_model
  import rhs_pkg::*;
(
  input  wire logic clk_i,   // clock for idle pattern
  input  wire logic no_ss_i, // strapped without select
  input  wire logic sclk_i,  // serial clock
  input  wire logic mosi_i,  // serial in
  input  wire logic ss_n_i,  // select
  output logic      miso_o,  // serial out
  output logic      irq_o    // interrupt
);
  logic [7:0] irq_st, mask, len_hi, len_lo, sh, out; // registers, shifters
  logic [7:0] fifo [12];                             // twelve byte fifo
  logic [3:0] cnt, bits;                             // bytes stored, bits seen
  logic [4:0] adr;                                   // register pointer
  logic       act, first, rd, cont, dummy;           // frame state
  assign irq_o = |irq_st;
  // register read mux
  function automatic logic [7:0] rd_reg(input logic [4:0] a);
    case (a)
      DEV_IRQ_STATUS:  rd_reg = irq_st;
      DEV_IRQ_MASK:    rd_reg = mask;
      DEV_FIFO_STATUS: rd_reg = {4'h0, cnt - 4'h1}; // count minus one
      DEV_TX_LEN_HIGH: rd_reg = len_hi;
      DEV_TX_LEN_LOW:  rd_reg = len_lo;
      default:         rd_reg = 8'h00;
    endcase
  endfunction
  // open or close a frame; status clears when a frame holding the extra read closes
  task automatic frame(input logic on);
    if (!on && dummy)
      irq_st = 8'h00;
    act = on;
    first = 1'b1;
    bits = 4'h0;
    rd = 1'b0;
    dummy = 1'b0;
  endtask
  initial begin
    {irq_st, mask, len_hi, len_lo, cnt, miso_o} = '0;
    frame(1'b0);
  end
  always @(negedge ss_n_i) if (!no_ss_i) frame(1'b1);
  always @(posedge ss_n_i) if (!no_ss_i) frame(1'b0);
  always @(posedge mosi_i) if (no_ss_i && sclk_i) frame(1'b1);
  always @(negedge mosi_i) if (no_ss_i && sclk_i) frame(1'b0);
  // sample on rising edges, msb first
  always @(posedge sclk_i) if (act) begin
    sh = {sh[6:0], mosi_i};
    bits = bits + 4'h1;
    if (bits == 4'h8) begin
      bits = 4'h0;
      if (first && sh[AW_CMD]) begin
        if (sh[4:0] == CMD_FIFO_RESET[4:0])
          cnt = 4'h0;
      end else if (first) begin
        adr = sh[4:0];
        rd = sh[AW_READ];
        cont = sh[AW_CONT];
      end else if (rd) begin
        dummy = dummy | (adr == DEV_IRQ_MASK);
        adr = adr + {4'h0, cont};
      end else begin
        case (adr)
          DEV_IRQ_MASK:    mask = sh;
          DEV_TX_LEN_HIGH: len_hi = sh;
          DEV_TX_LEN_LOW:  len_lo = sh;
          DEV_FIFO_DATA: begin          // transmit starts on first byte
            fifo[cnt] = sh;
            cnt = cnt + 4'h1;
            irq_st[IRQ_TX_BIT] = 1'b1;
          end
          default: ;
        endcase
        if (cont && adr != DEV_FIFO_DATA)
          adr = adr + 5'h01;
      end
      first = 1'b0;
      out = rd_reg(adr);
    end
  end
  // read data on falling edges after the address word
  always @(negedge sclk_i) if (act && rd && !first) begin
    miso_o = out[7];
    out = {out[6:0], 1'b0};
  end
  // undriven line shows a changing pattern
  always @(posedge clk_i) if (!(act && rd && !first)) miso_o <= ~miso_o;
endmodule // rhs_dev_model
`default_nettype wire

// File: dv/rhs_host_tb.sv
// self-checking bench for the reader host serial controller
`timescale 1ns/100ps
`default_nettype none
module rhs_host_tb
  import rhs_pkg::*;
;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o; // clock, reset, bus
  logic [7:0]  wb_adr_i;                                            // bus address
  logic [31:0] wb_dat_i, wb_dat_o;                                  // bus data
  logic [3:0]  wb_sel_i;                                            // byte selects
  logic        sclk_o, mosi_o, ss_n_o, miso_i, irq_i, no_ss;        // link pins
  int          fail_count, num_checks, cyc_n;                       // counters
  rhs_host i_rhs_host (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .sclk_o, .mosi_o, .ss_n_o, .miso_i, .irq_i);
  rhs_dev_model i_rhs_dev_model (.clk_i, .no_ss_i(no_ss), .sclk_i(sclk_o), .mosi_i(mosi_o),
    .ss_n_i(ss_n_o), .miso_o(miso_i), .irq_o(irq_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count++;
      test_done;
    end
  end
  // one classic wishbone cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(w, e, q);
  endtask
  // poll status until a bit reaches a level
  task automatic wait_bit(input int b, input logic v);
    logic [31:0] q;
    do wb(1'b0, ADR_STATUS, 32'h0, q); while (q[b] !== v);
  endtask
  task automatic op(input rhs_op_type c, input logic [7:0] b);
    wr(ADR_OP, {22'h0, c, b});
    wait_bit(STS_BUSY, 1'b0);
  endtask
  task automatic frame_wr(input logic [7:0] w [$]);
    op(OP_START, 8'h00);
    foreach (w[i]) op(OP_WRITE, w[i]);
    op(OP_STOP, 8'h00);
  endtask
  // read one register over the link and compare
  task automatic reg_rd(input string n, input logic [7:0] aw, input logic [7:0] e);
    op(OP_START, 8'h00);
    op(OP_WRITE, aw);
    op(OP_READ, 8'h00);
    op(OP_STOP, 8'h00);
    rd_chk(n, ADR_RXDATA, {24'h0, e});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, no_ss} = '0;
    {fail_count, num_checks} = '0;
    wb_sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("status", ADR_STATUS, 32'h0);
    rd_chk("ctrl", ADR_CTRL, {30'h0, CTRL_RESET});
    rd_chk("unmapped", 8'h14, 32'h0);
    $display("test reset done");
    frame_wr('{8'h80 | CMD_FIFO_RESET});
    frame_wr('{8'h3D, 8'h00, 8'h30, 8'hA5, 8'h3C, 8'h81});
    chk("len high", 32'h00, {24'h0, i_rhs_dev_model.len_hi});
    chk("len low", 32'h30, {24'h0, i_rhs_dev_model.len_lo});
    chk("fifo0", 32'hA5, {24'h0, i_rhs_dev_model.fifo[0]});
    chk("fifo2", 32'h81, {24'h0, i_rhs_dev_model.fifo[2]});
    rd_chk("irq level", ADR_STATUS, 32'h2);
    $display("test load done");
    reg_rd("fifo status", 8'h5C, 8'h02);
    reg_rd("len readback", 8'h5E, 8'h30);
    frame_wr('{8'h80 | CMD_FIFO_RESET});
    reg_rd("fifo emptied", 8'h5C, 8'h0F);
    $display("test read done");
    wr(ADR_CTRL, 32'h2);
    wait_bit(STS_IRQ_NEW, 1'b1);
    rd_chk("irq status", ADR_IRQSTAT, 32'h80);
    wait_bit(STS_IRQ, 1'b0);
    chk("cleared", 32'h0, {24'h0, i_rhs_dev_model.irq_st});
    wr(ADR_CTRL, 32'h0);
    $display("test service done");
    no_ss <= 1'b1;
    wr(ADR_CTRL, 32'h1);
    frame_wr('{8'h1D, 8'h5A});
    chk("len no select", 32'h5A, {24'h0, i_rhs_dev_model.len_hi});
    reg_rd("read no select", 8'h5D, 8'h5A);
    chk("select idle", 32'h1, {31'h0, ss_n_o});
    $display("test no select done");
    test_done;
  end
endmodule // rhs_host_tb
`default_nettype wire
